// [design/hflr_pkg.sv]
// Purpose: shared constants and types for the hands-free level regulation block
// Assumes: APB, 32-bit data; one-byte coefficients in dB-step units (0.5 dB per step)
// Notes:   gains are signed half-dB steps, positive is boost
package hflr_pkg;
  // register and coefficient ram byte offsets
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_STATUS     = 12'h004;
  localparam logic [11:0] OFS_COEF_BASE  = 12'h040;
  localparam logic [11:0] OFS_COEF_LAST  = 12'h07C;
  // coefficient indices inside coefficient_ram, per direction (tx 0..7, rx 8..15)
  localparam int          CF_TRIM        = 0;
  localparam int          CF_COMPARE     = 1;
  localparam int          CF_ATTEN       = 2;
  localparam int          CF_BOOST       = 3;
  localparam int          CF_HIGH_TC     = 4;
  localparam int          CF_LOW_TC      = 5;
  localparam int          CF_NOISE       = 6;
  localparam int          CF_INIT        = 7;
  localparam int          CF_RX_BASE     = 8;
  localparam int          CF_COUNT       = 16;
  // control register fields
  localparam int          CTL_HF_EN      = 0;
  localparam int          CTL_TX_REG_EN  = 1;
  localparam int          CTL_RX_REG_EN  = 2;
  localparam int          CTL_RX_TAP     = 3;
  localparam logic [3:0]  CTRL_RST       = 4'h0;
  localparam logic [7:0]  COEF_RST       = 8'h00;
  // time constant unit: one step per ms/dB, at 100 MHz clock
  localparam int          CLK_MHZ        = 100;
  localparam int          TC_UNIT_US     = 1000;
  localparam int          TC_UNIT_CYC    = TC_UNIT_US * CLK_MHZ / 2;   // half-dB step
  localparam logic [31:0] TC_UNIT        = 32'(TC_UNIT_CYC);
  localparam logic [31:0] APB_ERR_DATA   = 32'h0000_0000;

  typedef struct packed {
    logic signed [15:0] level;   // log level, half-dB steps, 0 = full-scale pcm
    logic signed [15:0] noise;   // background noise level, same scale
    logic               valid;   // one-cycle sample strobe
  } hflr_sample_type;
endpackage

// [design/hflr_top.sv]
// Purpose: tx and rx automatic level regulators for a hands-free voice path
// Assumes: levels arrive as log values per sample; partner drives talk direction
// Notes:   apb slave holds control, status and coefficient ram; zero-wait answers
`timescale 1ns/1ps
`default_nettype none
module hflr_top (
  input  wire logic                      SYS_CLK_I,     // 100 MHz clock
  input  wire logic                      SRST_I,        // sync reset, high
  input  wire logic                      PSEL_I,        // apb select
  input  wire logic                      PENABLE_I,     // apb access phase
  input  wire logic                      PWRITE_I,      // apb direction
  input  wire logic [11:0]               PADDR_I,       // apb byte address
  input  wire logic [31:0]               PWDATA_I,      // apb write data
  output logic      [31:0]               PRDATA_O,      // apb read data
  output logic                           PREADY_O,      // apb ready
  output logic                           PSLVERR_O,     // apb error
  input  wire logic                      RX_MODE_I,     // 1 receive mode, 0 transmit
  input  wire hflr_pkg::hflr_sample_type TX_IN_I,       // tx level after detector
  input  wire hflr_pkg::hflr_sample_type RX_IN_I,       // rx level from line
  output logic signed [15:0]             TX_GAIN_O,     // tx regulator plus trim gain
  output logic signed [15:0]             RX_GAIN_O,     // rx regulator plus trim gain
  output logic signed [15:0]             RX_DET_LEVEL_O,// rx speech detector input level
  output logic signed [15:0]             SWEEP_ADJ_O    // sweep range offset for attenuation
);
  logic [3:0]  ctrl_r;
  logic [7:0]  coef_r [hflr_pkg::CF_COUNT];
  logic        wr_en;
  logic        rd_en;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_coef;
  logic [3:0]  coef_idx;
  logic        hf_en;
  logic [1:0]  reg_en;
  logic [1:0]  hold;
  logic [1:0]  smp;
  logic signed [15:0] lvl   [2];
  logic signed [15:0] nse   [2];
  logic signed [15:0] reg_gain [2];
  logic signed [15:0] trim_gain [2];

  assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_en    = PSEL_I & PENABLE_I & ~PWRITE_I;
  assign hit_ctrl = (PADDR_I == hflr_pkg::OFS_CTRL);
  assign hit_stat = (PADDR_I == hflr_pkg::OFS_STATUS);
  assign hit_coef = (PADDR_I >= hflr_pkg::OFS_COEF_BASE) && (PADDR_I <= hflr_pkg::OFS_COEF_LAST)
                    && (PADDR_I[1:0] == 2'b00);
  assign coef_idx = 4'((PADDR_I - hflr_pkg::OFS_COEF_BASE) >> 2);
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~(hit_ctrl | hit_coef | (hit_stat & ~PWRITE_I));

  assign hf_en  = ctrl_r[hflr_pkg::CTL_HF_EN];
  assign reg_en = {ctrl_r[hflr_pkg::CTL_RX_REG_EN], ctrl_r[hflr_pkg::CTL_TX_REG_EN]} &
                  {2{hf_en}};
  assign hold   = {~RX_MODE_I, RX_MODE_I};
  assign smp    = {RX_IN_I.valid, TX_IN_I.valid};
  assign lvl[0] = TX_IN_I.level;
  assign lvl[1] = RX_IN_I.level;
  assign nse[0] = TX_IN_I.noise;
  assign nse[1] = RX_IN_I.noise;

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      ctrl_r <= hflr_pkg::CTRL_RST;
    end else if (wr_en && hit_ctrl) begin
      ctrl_r <= PWDATA_I[3:0];
    end
  end

  // coefficient bytes are stored at once; regulators and trim read them combinationally every cycle
  for (genvar c = 0; c < hflr_pkg::CF_COUNT; c++) begin : g_coef
    always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
        coef_r[c] <= hflr_pkg::COEF_RST;
      end else if (wr_en && hit_coef && coef_idx == 4'(c)) begin
        coef_r[c] <= PWDATA_I[7:0];
      end
    end
  end

  // one regulator per direction; d=0 tx, d=1 rx
  for (genvar d = 0; d < 2; d++) begin : g_reg
    localparam int B = d * hflr_pkg::CF_RX_BASE;
    logic signed [15:0] gain_r;
    logic signed [15:0] gain_nxt;
    logic        [31:0] tc_cnt_r;
    logic        [31:0] tc_cnt_nxt;
    logic        [31:0] tc_lim;
    logic               en_d_r;
    logic signed [15:0] cmp_lvl;
    logic signed [15:0] nse_thr;
    logic signed [15:0] nse_cut;
    logic signed [15:0] max_g;
    logic signed [15:0] min_g;
    logic signed [15:0] init_g;
    logic signed [15:0] out_lvl;
    logic               above;
    logic               step_due;

    // compare and noise thresholds are negative dB below full scale
    assign cmp_lvl = -$signed({8'h00, coef_r[B + hflr_pkg::CF_COMPARE]});
    assign nse_thr = -$signed({8'h00, coef_r[B + hflr_pkg::CF_NOISE]});
    assign nse_cut = (nse[d] > nse_thr) ? 16'(nse[d] - nse_thr) : 16'sh0000;
    assign max_g   = $signed({8'h00, coef_r[B + hflr_pkg::CF_BOOST]}) - nse_cut;
    assign min_g   = -$signed({8'h00, coef_r[B + hflr_pkg::CF_ATTEN]});
    // rx initial level is signed so it reaches both boost and attenuation
    assign init_g  = (d == 1) ? 16'($signed(coef_r[B + hflr_pkg::CF_INIT]))
                              : $signed({8'h00, coef_r[B + hflr_pkg::CF_INIT]});
    assign out_lvl = 16'(lvl[d] + gain_r);
    assign above   = out_lvl > cmp_lvl;
    assign tc_lim  = (above ? {24'h00_0000, coef_r[B + hflr_pkg::CF_HIGH_TC]}
                            : {24'h00_0000, coef_r[B + hflr_pkg::CF_LOW_TC]}) * hflr_pkg::TC_UNIT
                     ;
    assign step_due = (tc_cnt_r >= tc_lim);

    always_comb begin
      gain_nxt   = gain_r;
      tc_cnt_nxt = tc_cnt_r;
      if (!reg_en[d]) begin
        gain_nxt   = 16'sh0000;
        tc_cnt_nxt = 32'h0000_0000;
      end else if (!en_d_r) begin
        gain_nxt   = init_g;
        tc_cnt_nxt = 32'h0000_0000;
      end else if (!hold[d]) begin
        tc_cnt_nxt = step_due ? 32'h0000_0000 : tc_cnt_r + 32'h0000_0001;
        if (smp[d] && step_due) begin
          if (above) begin
            gain_nxt = 16'(gain_r - 16'sh0001);
          end else begin
            gain_nxt = 16'(gain_r + 16'sh0001);
          end
        end
        if (smp[d]) begin
          if (gain_nxt > max_g) begin
            gain_nxt = max_g;
          end else if (gain_nxt < min_g) begin
            gain_nxt = min_g;
          end
        end
      end
    end

    always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
        gain_r   <= 16'sh0000;
        tc_cnt_r <= 32'h0000_0000;
        en_d_r   <= 1'b0;
      end else begin
        gain_r   <= gain_nxt;
        tc_cnt_r <= tc_cnt_nxt;
        en_d_r   <= reg_en[d];
      end
    end

    assign reg_gain[d]  = gain_r;
    // trim follows hands-free enable only, not the regulator enable
    assign trim_gain[d] = hf_en ? 16'($signed(coef_r[B + hflr_pkg::CF_TRIM])) : 16'sh0000;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      TX_GAIN_O      <= 16'sh0000;
      RX_GAIN_O      <= 16'sh0000;
      RX_DET_LEVEL_O <= 16'sh0000;
      SWEEP_ADJ_O    <= 16'sh0000;
      PRDATA_O       <= hflr_pkg::APB_ERR_DATA;
    end else begin
      TX_GAIN_O      <= 16'(reg_gain[0] + trim_gain[0]);
      RX_GAIN_O      <= 16'(reg_gain[1] + trim_gain[1]);
      RX_DET_LEVEL_O <= ctrl_r[hflr_pkg::CTL_RX_TAP] ? lvl[1]
                                                     : 16'(lvl[1] + reg_gain[1]);
      // the sum of both regulator gains, boost and cut, is handed back to the attenuation sweep
      SWEEP_ADJ_O    <= 16'(reg_gain[0] + reg_gain[1]);
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
        if (hit_ctrl) begin
          PRDATA_O <= {28'h000_0000, ctrl_r};
        end else if (hit_stat) begin
          PRDATA_O <= {reg_gain[1], reg_gain[0]};
        end else if (hit_coef) begin
          PRDATA_O <= {24'h00_0000, coef_r[coef_idx]};
        end else begin
          PRDATA_O <= hflr_pkg::APB_ERR_DATA;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb/hflr_checker.sv]
// Purpose: port assertions for hflr_top
// Assumes: ctrl bits shadowed from apb writes
// Notes:   q_r counts quiet cycles after a write or a mode change
`timescale 1ns/1ps
`default_nettype none
module hflr_checker (
  input wire logic                      SYS_CLK_I,
  input wire logic                      SRST_I,
  input wire logic                      PSEL_I,
  input wire logic                      PENABLE_I,
  input wire logic                      PWRITE_I,
  input wire logic [11:0]               PADDR_I,
  input wire logic [31:0]               PWDATA_I,
  input wire logic                      PREADY_O,
  input wire logic                      PSLVERR_O,
  input wire logic                      RX_MODE_I,
  input wire hflr_pkg::hflr_sample_type TX_IN_I,
  input wire logic signed [15:0]        TX_GAIN_O,
  input wire logic signed [15:0]        RX_GAIN_O
);
  logic       wr, hf_r, tx_r, md_r;
  logic [2:0] q_r;
  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  always_ff @(posedge SYS_CLK_I) begin
    md_r <= RX_MODE_I;
    q_r  <= (SRST_I || wr || RX_MODE_I != md_r) ? 3'h0 : q_r + 3'(q_r != 3'h7);
    if (SRST_I || (wr && PADDR_I == hflr_pkg::OFS_CTRL))
      {tx_r, hf_r} <= SRST_I ? 2'h0 : PWDATA_I[1:0];
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);
  sequence s_quiet;
    q_r >= 3'h3;
  endsequence
  a_ready_high: assert property (PREADY_O) else $error("ready low");
  a_err_access: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I) else $error("stray error");
  a_status_wr_err: assert property (wr && PADDR_I == hflr_pkg::OFS_STATUS |-> PSLVERR_O)
    else $error("status write accepted");
  a_tx_held: assert property (s_quiet and RX_MODE_I |-> $stable(TX_GAIN_O))
    else $error("tx gain moved in receive mode");
  a_rx_held: assert property (s_quiet and !RX_MODE_I |-> $stable(RX_GAIN_O))
    else $error("rx gain moved in transmit mode");
  a_tx_one_step: assert property (s_quiet |-> (TX_GAIN_O - $past(TX_GAIN_O)) inside {-1, 0, 1})
    else $error("tx gain jumped");
  a_tx_step_cause: assert property (q_r >= 3'h4 && $changed(TX_GAIN_O) |->
    $past(TX_IN_I.valid) || $past(TX_IN_I.valid, 2) || $past(TX_IN_I.valid, 3))
    else $error("tx gain moved without a sample");
  a_off_zero: assert property (s_quiet and !hf_r |-> TX_GAIN_O == 0 && RX_GAIN_O == 0)
    else $error("gain while hands-free off");
  a_trim_only: assert property (s_quiet and hf_r && !tx_r |-> $stable(TX_GAIN_O))
    else $error("tx gain moved with regulator off");
endmodule
bind hflr_top hflr_checker u_chk (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RX_MODE_I(RX_MODE_I), .TX_IN_I(TX_IN_I),
  .TX_GAIN_O(TX_GAIN_O), .RX_GAIN_O(RX_GAIN_O));
`default_nettype wire

// [tb/hflr_partner.sv]
// Purpose: far side stand-in: talk direction and level samples
// Assumes: bench picks levels and direction
// Notes:   one valid pulse every fourth cycle while run is high
`timescale 1ns/1ps
`default_nettype none
module hflr_partner (
  input  wire logic                 clk_i,    // clock
  input  wire logic                 run_i,    // emit samples
  input  wire logic                 rx_i,     // wanted direction
  input  wire logic signed [15:0]   tx_lvl_i, // tx level
  input  wire logic signed [15:0]   rx_lvl_i, // rx level
  output var  logic                 mode_o = 1'b0, // receive mode
  output var  hflr_pkg::hflr_sample_type tx_o = '0, // tx sample
  output var  hflr_pkg::hflr_sample_type rx_o = '0  // rx sample
);
  logic [1:0] ph_r = 2'h0;
  always @(posedge clk_i) begin
    ph_r   <= ph_r + 2'h1;
    mode_o <= rx_i;
    // tx noise 5 dB above a 10 dB threshold, rx noise far below
    tx_o   <= '{level: tx_lvl_i, noise: 16'hFFF6, valid: run_i && ph_r == 2'h0};
    rx_o   <= '{level: rx_lvl_i, noise: 16'hFF9C, valid: run_i && ph_r == 2'h2};
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench for hflr_top
// Assumes: time constants 0, so every valid sample of the direction not held by the mode moves one step until the boost or attenuation limit clamps it
// Notes:   coefficient bytes are raw half-dB step counts
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, run = 1'b0, rxm = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0000_0000, prd, rd;
  logic        pready, perr, err;
  logic signed [15:0] txg, rxg, det, swp;
  hflr_pkg::hflr_sample_type txs, rxs;
  logic        mode;
  int          error_cnt = 0, total_checks = 0, cyc = 0;
  int          ci[9] = '{1, 2, 3, 6, 7, 9, 10, 11, 15};
  int          cv[9] = '{20, 8, 20, 20, 4, 20, 8, 0, 3};
  hflr_top dut (.SYS_CLK_I(clk), .SRST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
    .RX_MODE_I(mode), .TX_IN_I(txs), .RX_IN_I(rxs), .TX_GAIN_O(txg), .RX_GAIN_O(rxg),
    .RX_DET_LEVEL_O(det), .SWEEP_ADJ_O(swp));
  hflr_partner far (.clk_i(clk), .run_i(run), .rx_i(rxm), .tx_lvl_i(16'hFF88),
    .rx_lvl_i(16'h0000), .mode_o(mode), .tx_o(txs), .rx_o(rxs));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prd; err = perr; psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic coef(input int i, input int v);
    apb(1'b1, hflr_pkg::OFS_COEF_BASE + 12'(4 * i), 32'(v));
  endtask
  task automatic t_regs();
    apb(1'b0, hflr_pkg::OFS_CTRL, 0); chk(rd, 32'h0000_0000);
    apb(1'b0, hflr_pkg::OFS_STATUS, 0); chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h100, 0); chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    apb(1'b1, hflr_pkg::OFS_STATUS, 1); chk(32'(err), 32'h1);
  endtask
  task automatic t_trim();
    coef(hflr_pkg::CF_TRIM, 6);
    apb(1'b1, hflr_pkg::OFS_CTRL, 1); repeat (4) @(posedge clk);
    chk(32'(txg), 32'h6);
    apb(1'b1, hflr_pkg::OFS_CTRL, 0); repeat (4) @(posedge clk);
    chk(32'(txg), 32'h0);
    coef(hflr_pkg::CF_TRIM, 0);
  endtask
  task automatic t_regulate();
    for (int k = 0; k < 9; k++) coef(ci[k], cv[k]);
    apb(1'b1, hflr_pkg::OFS_CTRL, 7); repeat (4) @(posedge clk);
    chk(32'(txg), 32'h4);
    chk(32'(rxg), 32'h3);
    run <= 1'b1; repeat (100) @(posedge clk);
    chk(32'(txg), 32'hA);
    chk(32'(rxg), 32'h3);
    rxm <= 1'b1; repeat (100) @(posedge clk);
    chk(32'(rxg), 32'hFFFF_FFF8);
    chk(32'(txg), 32'hA);
    chk(32'(swp), 32'h2);
    apb(1'b0, hflr_pkg::OFS_STATUS, 0); chk(rd, 32'hFFF8_000A);
    chk(32'(det), 32'hFFFF_FFF8);
    apb(1'b1, hflr_pkg::OFS_CTRL, 15); repeat (4) @(posedge clk);
    chk(32'(det), 32'h0000_0000);
    chk(32'(rxg), 32'hFFFF_FFF8);
    apb(1'b1, hflr_pkg::OFS_CTRL, 0); repeat (4) @(posedge clk);
    chk({txg, rxg}, 32'h0000_0000);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_trim();
    t_regulate();
    end_sim();
  end
endmodule
`default_nettype wire
